// ### counter_array_pkg.sv
package counter_array_pkg;
  localparam int MODULE_COUNT = 5;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'hF9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_MODULE0_VALUE_LOW = 8'hFB;
  localparam logic [7:0] ADDR_MODULE0_VALUE_HIGH = 8'hFC;
  localparam logic [7:0] ADDR_MODULE1_VALUE_LOW = 8'hE9;
  localparam logic [7:0] ADDR_MODULE1_VALUE_HIGH = 8'hEA;
  localparam logic [7:0] ADDR_MODULE2_VALUE_LOW = 8'hEB;
  localparam logic [7:0] ADDR_MODULE2_VALUE_HIGH = 8'hEC;
  localparam logic [7:0] ADDR_MODULE3_VALUE_LOW = 8'hED;
  localparam logic [7:0] ADDR_MODULE3_VALUE_HIGH = 8'hEE;
  localparam logic [7:0] ADDR_MODULE4_VALUE_LOW = 8'hFD;
  localparam logic [7:0] ADDR_MODULE4_VALUE_HIGH = 8'hFE;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ### module_compare.sv
`timescale 1ns/1ps
module module_compare (
  input wire logic clk,
  input wire logic rst,
  input wire logic write_low,
  input wire logic write_high,
  input wire logic [7:0] write_data,
  input wire logic [15:0] counter,
  input wire logic match_enable,
  input wire logic flag_clear,
  output logic [15:0] module_value,
  output logic comparator_enable,
  output logic capture_compare_flag
);
  import counter_array_pkg::*;

  typedef struct packed {
    logic [15:0] value;
    logic comp_en;
    logic flag;
  } cmp_state_t;

  cmp_state_t state_reg;
  cmp_state_t state_next;
  logic hit;

  always_comb begin
    state_next = state_reg;
    hit = state_reg.comp_en && match_enable && (counter == state_reg.value);
    if (write_low) begin
      state_next.value[7:0] = write_data;
      state_next.comp_en = 1'b0;
    end else if (write_high) begin
      state_next.value[15:8] = write_data;
      state_next.comp_en = 1'b1;
    end
    // A match in the same cycle as the clear must not be lost, so set wins.
    if (flag_clear) begin
      state_next.flag = 1'b0;
    end
    if (hit) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{value: RESET_WORD, comp_en: 1'b0, flag: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign module_value = state_reg.value;
  assign comparator_enable = state_reg.comp_en;
  assign capture_compare_flag = state_reg.flag;

  low_clears_a: assert property (@(posedge clk) disable iff (rst)
    write_low |=> !comparator_enable) else $error("low write left comparator enabled");
  high_sets_a: assert property (@(posedge clk) disable iff (rst)
    write_high && !write_low |=> comparator_enable) else $error("high write did not enable comparator");
  match_flag_a: assert property (@(posedge clk) disable iff (rst)
    comparator_enable && match_enable && counter == module_value |=> capture_compare_flag)
    else $error("match did not set flag");
  no_match_a: assert property (@(posedge clk) disable iff (rst)
    !comparator_enable && !capture_compare_flag |=> !capture_compare_flag)
    else $error("flag set with comparator disabled");
  clear_flag_a: assert property (@(posedge clk) disable iff (rst)
    flag_clear && !(comparator_enable && match_enable && counter == module_value) |=> !capture_compare_flag)
    else $error("flag survived a clear without a match");
endmodule

// ### counter_snapshot.sv
`timescale 1ns/1ps
module counter_snapshot (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic write_low,
  input wire logic write_high,
  input wire logic read_low,
  input wire logic [7:0] write_data,
  output logic [15:0] counter,
  output logic [7:0] snapshot
);
  import counter_array_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] snap;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (run) begin
      state_next.count = state_reg.count + COUNT_STEP;
    end
    // Writes arrive already gated by the watchdog lock.
    if (write_low) begin
      state_next.count[7:0] = write_data;
    end
    if (write_high) begin
      state_next.count[15:8] = write_data;
    end
    if (read_low) begin
      state_next.snap = state_reg.count[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{count: RESET_WORD, snap: RESET_BYTE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign counter = state_reg.count;
  assign snapshot = state_reg.snap;

  snap_load_a: assert property (@(posedge clk) disable iff (rst)
    read_low |=> snapshot == $past(counter[15:8])) else $error("snapshot not loaded on low read");
  snap_hold_a: assert property (@(posedge clk) disable iff (rst)
    !read_low |=> snapshot == $past(snapshot)) else $error("snapshot changed without low read");
endmodule

// ### counter_array_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Counter low at F9, high at FA.
// - High read returns snapshot latched on low read.
// - Watchdog enabled blocks counter byte writes.
// - Module value low bytes at documented addresses.
// - Module value high bytes at documented addresses.
// - Low byte write clears comparator enable.
// - High byte write sets comparator enable.
// - Registers reachable on every page.
// - Comparator enable gates compare against counter.
// - Match sets the module's capture/compare flag.
module counter_array_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] page,
  input wire logic write_en,
  input wire logic read_en,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data,
  input wire logic counter_run,
  input wire logic watchdog_enable,
  input wire logic [counter_array_pkg::MODULE_COUNT-1:0] match_enable,
  input wire logic [counter_array_pkg::MODULE_COUNT-1:0] flag_clear,
  output logic [15:0] array_counter,
  output logic [counter_array_pkg::MODULE_COUNT-1:0] comparator_enable,
  output logic [counter_array_pkg::MODULE_COUNT-1:0] capture_compare_flag
);
  import counter_array_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] low_addr(input int idx);
    logic [7:0] a;
    a = ADDR_MODULE0_VALUE_LOW;
    if (idx == 1) begin
      a = ADDR_MODULE1_VALUE_LOW;
    end else if (idx == 2) begin
      a = ADDR_MODULE2_VALUE_LOW;
    end else if (idx == 3) begin
      a = ADDR_MODULE3_VALUE_LOW;
    end else if (idx == 4) begin
      a = ADDR_MODULE4_VALUE_LOW;
    end
    return a;
  endfunction

  function automatic logic [7:0] high_addr(input int idx);
    logic [7:0] a;
    a = ADDR_MODULE0_VALUE_HIGH;
    if (idx == 1) begin
      a = ADDR_MODULE1_VALUE_HIGH;
    end else if (idx == 2) begin
      a = ADDR_MODULE2_VALUE_HIGH;
    end else if (idx == 3) begin
      a = ADDR_MODULE3_VALUE_HIGH;
    end else if (idx == 4) begin
      a = ADDR_MODULE4_VALUE_HIGH;
    end
    return a;
  endfunction

  // The page input is deliberately ignored: these bytes sit in every page.
  logic unused_page;
  assign unused_page = ^page;

  logic counter_write_ok;
  logic cnt_wr_low;
  logic cnt_wr_high;
  logic cnt_rd_low;
  logic [7:0] snapshot;
  logic [MODULE_COUNT-1:0] mod_wr_low;
  logic [MODULE_COUNT-1:0] mod_wr_high;
  logic [15:0] module_value [MODULE_COUNT];

  assign counter_write_ok = write_en && !watchdog_enable;
  assign cnt_wr_low = counter_write_ok && (addr == ADDR_COUNTER_LOW);
  assign cnt_wr_high = counter_write_ok && (addr == ADDR_COUNTER_HIGH);
  assign cnt_rd_low = read_en && (addr == ADDR_COUNTER_LOW);

  always_comb begin
    for (int i = 0; i < MODULE_COUNT; i++) begin
      mod_wr_low[i] = write_en && (addr == low_addr(i));
      mod_wr_high[i] = write_en && (addr == high_addr(i));
    end
  end

  // ----------------------------------------------------------------
  // Counter and modules
  // ----------------------------------------------------------------
  counter_snapshot counter_unit (
    .clk(clk),
    .rst(rst),
    .run(counter_run),
    .write_low(cnt_wr_low),
    .write_high(cnt_wr_high),
    .read_low(cnt_rd_low),
    .write_data(write_data),
    .counter(array_counter),
    .snapshot(snapshot)
  );

  for (genvar g = 0; g < MODULE_COUNT; g++) begin : g_mod
    module_compare cmp_unit (
      .clk(clk),
      .rst(rst),
      .write_low(mod_wr_low[g]),
      .write_high(mod_wr_high[g]),
      .write_data(write_data),
      .counter(array_counter),
      .match_enable(match_enable[g]),
      .flag_clear(flag_clear[g]),
      .module_value(module_value[g]),
      .comparator_enable(comparator_enable[g]),
      .capture_compare_flag(capture_compare_flag[g])
    );
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
  } rd_state_t;

  rd_state_t state_reg;
  rd_state_t state_next;

  // Read data is registered, so it appears one cycle after read_en.
  always_comb begin
    state_next = state_reg;
    if (read_en) begin
      state_next.rdata = UNMAPPED_READ;
      if (addr == ADDR_COUNTER_LOW) begin
        state_next.rdata = array_counter[7:0];
      end else if (addr == ADDR_COUNTER_HIGH) begin
        state_next.rdata = snapshot;
      end
      for (int i = 0; i < MODULE_COUNT; i++) begin
        if (addr == low_addr(i)) begin
          state_next.rdata = module_value[i][7:0];
        end else if (addr == high_addr(i)) begin
          state_next.rdata = module_value[i][15:8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{rdata: RESET_BYTE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign read_data = state_reg.rdata;

  // ----------------------------------------------------------------
  // Checks on the counter
  // ----------------------------------------------------------------
  // Byte checks hold only while the counter is stopped, since a running count moves the other byte.
  wd_lock_a: assert property (@(posedge clk) disable iff (rst)
    watchdog_enable && write_en && addr == ADDR_COUNTER_HIGH && !counter_run
    |=> array_counter == $past(array_counter)) else $error("counter written while watchdog on");
  wd_low_lock_a: assert property (@(posedge clk) disable iff (rst)
    watchdog_enable && write_en && addr == ADDR_COUNTER_LOW && !counter_run
    |=> array_counter == $past(array_counter)) else $error("counter low written while watchdog on");
  cnt_write_a: assert property (@(posedge clk) disable iff (rst)
    !watchdog_enable && write_en && addr == ADDR_COUNTER_LOW && !counter_run
    |=> array_counter[7:0] == $past(write_data)) else $error("counter low write lost");
  cnt_high_write_a: assert property (@(posedge clk) disable iff (rst)
    !watchdog_enable && write_en && addr == ADDR_COUNTER_HIGH && !counter_run
    |=> array_counter[15:8] == $past(write_data)) else $error("counter high write lost");
  cnt_hold_a: assert property (@(posedge clk) disable iff (rst)
    !counter_run && !cnt_wr_low && !cnt_wr_high |=> array_counter == $past(array_counter))
    else $error("counter moved without run or write");
  cnt_step_a: assert property (@(posedge clk) disable iff (rst)
    counter_run && !cnt_wr_low && !cnt_wr_high |=> array_counter == $past(array_counter) + COUNT_STEP)
    else $error("counter did not step by one");

  // ----------------------------------------------------------------
  // Checks on reads and decode
  // ----------------------------------------------------------------
  high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_COUNTER_HIGH |=> read_data == $past(snapshot))
    else $error("high read did not return snapshot");
  low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_COUNTER_LOW |=> read_data == $past(array_counter[7:0]))
    else $error("low read did not return counter byte");
  snap_keep_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_COUNTER_HIGH |=> snapshot == $past(snapshot))
    else $error("high write disturbed snapshot");
  read_hold_a: assert property (@(posedge clk) disable iff (rst)
    !read_en |=> read_data == $past(read_data)) else $error("read data changed without read");
  one_target_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0({mod_wr_low, mod_wr_high, cnt_wr_low, cnt_wr_high})) else $error("write decoded to two registers");

  // ----------------------------------------------------------------
  // Checks on module writes
  // ----------------------------------------------------------------
  // Each address gets its own check, so a decode slip between neighbours shows in exactly one of them.
  mod0_low_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE0_VALUE_LOW |=> module_value[0][7:0] == $past(write_data) && !comparator_enable[0])
    else $error("module 0 low write wrong");
  low_value_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE1_VALUE_LOW |=> module_value[1][7:0] == $past(write_data) && !comparator_enable[1])
    else $error("module 1 low write wrong");
  mod2_low_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE2_VALUE_LOW |=> module_value[2][7:0] == $past(write_data) && !comparator_enable[2])
    else $error("module 2 low write wrong");
  mod3_low_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE3_VALUE_LOW |=> module_value[3][7:0] == $past(write_data) && !comparator_enable[3])
    else $error("module 3 low write wrong");
  mod4_low_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE4_VALUE_LOW |=> module_value[4][7:0] == $past(write_data) && !comparator_enable[4])
    else $error("module 4 low write wrong");
  page_free_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE0_VALUE_HIGH && page != RESET_BYTE
    |=> comparator_enable[0] && module_value[0][15:8] == $past(write_data))
    else $error("write depended on page");
  mod1_high_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE1_VALUE_HIGH |=> module_value[1][15:8] == $past(write_data) && comparator_enable[1])
    else $error("module 1 high write wrong");
  mod2_high_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE2_VALUE_HIGH |=> module_value[2][15:8] == $past(write_data) && comparator_enable[2])
    else $error("module 2 high write wrong");
  mod3_high_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE3_VALUE_HIGH |=> module_value[3][15:8] == $past(write_data) && comparator_enable[3])
    else $error("module 3 high write wrong");
  high_value_a: assert property (@(posedge clk) disable iff (rst)
    write_en && addr == ADDR_MODULE4_VALUE_HIGH |=> module_value[4][15:8] == $past(write_data) && comparator_enable[4])
    else $error("module 4 high write wrong");

  // ----------------------------------------------------------------
  // Checks on module reads
  // ----------------------------------------------------------------
  mod0_low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE0_VALUE_LOW |=> read_data == $past(module_value[0][7:0]))
    else $error("module 0 low read wrong");
  mod1_low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE1_VALUE_LOW |=> read_data == $past(module_value[1][7:0]))
    else $error("module 1 low read wrong");
  mod2_low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE2_VALUE_LOW |=> read_data == $past(module_value[2][7:0]))
    else $error("module 2 low read wrong");
  mod3_low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE3_VALUE_LOW |=> read_data == $past(module_value[3][7:0]))
    else $error("module 3 low read wrong");
  mod4_low_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE4_VALUE_LOW |=> read_data == $past(module_value[4][7:0]))
    else $error("module 4 low read wrong");
  mod0_high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE0_VALUE_HIGH |=> read_data == $past(module_value[0][15:8]))
    else $error("module 0 high read wrong");
  mod1_high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE1_VALUE_HIGH |=> read_data == $past(module_value[1][15:8]))
    else $error("module 1 high read wrong");
  mod2_high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE2_VALUE_HIGH |=> read_data == $past(module_value[2][15:8]))
    else $error("module 2 high read wrong");
  mod3_high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE3_VALUE_HIGH |=> read_data == $past(module_value[3][15:8]))
    else $error("module 3 high read wrong");
  mod4_high_read_a: assert property (@(posedge clk) disable iff (rst)
    read_en && addr == ADDR_MODULE4_VALUE_HIGH |=> read_data == $past(module_value[4][15:8]))
    else $error("module 4 high read wrong");

  // ----------------------------------------------------------------
  // Checks on module state between writes
  // ----------------------------------------------------------------
  mod0_hold_a: assert property (@(posedge clk) disable iff (rst)
    !mod_wr_low[0] && !mod_wr_high[0]
    |=> module_value[0] == $past(module_value[0]) && comparator_enable[0] == $past(comparator_enable[0]))
    else $error("module 0 changed without a write");
  mod1_hold_a: assert property (@(posedge clk) disable iff (rst)
    !mod_wr_low[1] && !mod_wr_high[1]
    |=> module_value[1] == $past(module_value[1]) && comparator_enable[1] == $past(comparator_enable[1]))
    else $error("module 1 changed without a write");
  mod2_hold_a: assert property (@(posedge clk) disable iff (rst)
    !mod_wr_low[2] && !mod_wr_high[2]
    |=> module_value[2] == $past(module_value[2]) && comparator_enable[2] == $past(comparator_enable[2]))
    else $error("module 2 changed without a write");
  mod3_hold_a: assert property (@(posedge clk) disable iff (rst)
    !mod_wr_low[3] && !mod_wr_high[3]
    |=> module_value[3] == $past(module_value[3]) && comparator_enable[3] == $past(comparator_enable[3]))
    else $error("module 3 changed without a write");
  mod4_hold_a: assert property (@(posedge clk) disable iff (rst)
    !mod_wr_low[4] && !mod_wr_high[4]
    |=> module_value[4] == $past(module_value[4]) && comparator_enable[4] == $past(comparator_enable[4]))
    else $error("module 4 changed without a write");
  mod0_flag_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(match_enable[0] && comparator_enable[0]) && !capture_compare_flag[0] |=> !capture_compare_flag[0])
    else $error("module 0 flag rose without match");
  mod1_flag_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(match_enable[1] && comparator_enable[1]) && !capture_compare_flag[1] |=> !capture_compare_flag[1])
    else $error("module 1 flag rose without match");
  mod2_flag_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(match_enable[2] && comparator_enable[2]) && !capture_compare_flag[2] |=> !capture_compare_flag[2])
    else $error("module 2 flag rose without match");
  mod3_flag_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(match_enable[3] && comparator_enable[3]) && !capture_compare_flag[3] |=> !capture_compare_flag[3])
    else $error("module 3 flag rose without match");
  mod4_flag_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(match_enable[4] && comparator_enable[4]) && !capture_compare_flag[4] |=> !capture_compare_flag[4])
    else $error("module 4 flag rose without match");
endmodule

// ### counter_array_regs_test.sv
`timescale 1ns/1ps
module counter_array_regs_test;
  import counter_array_pkg::*;
  localparam int CYCLE_CEILING = 2000;
  logic clk, rst, write_en, read_en, counter_run, watchdog_enable;
  logic [7:0] addr, page, write_data, read_data, rd;
  logic [MODULE_COUNT-1:0] match_enable, flag_clear, comparator_enable, capture_compare_flag;
  logic [15:0] array_counter;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] low_addr [MODULE_COUNT] = '{ADDR_MODULE0_VALUE_LOW, ADDR_MODULE1_VALUE_LOW,
    ADDR_MODULE2_VALUE_LOW, ADDR_MODULE3_VALUE_LOW, ADDR_MODULE4_VALUE_LOW};
  logic [7:0] high_addr [MODULE_COUNT] = '{ADDR_MODULE0_VALUE_HIGH, ADDR_MODULE1_VALUE_HIGH,
    ADDR_MODULE2_VALUE_HIGH, ADDR_MODULE3_VALUE_HIGH, ADDR_MODULE4_VALUE_HIGH};

  counter_array_regs dut_u (.clk(clk), .rst(rst), .addr(addr), .page(page), .write_en(write_en),
    .read_en(read_en), .write_data(write_data), .read_data(read_data), .counter_run(counter_run),
    .watchdog_enable(watchdog_enable), .match_enable(match_enable), .flag_clear(flag_clear),
    .array_counter(array_counter), .comparator_enable(comparator_enable),
    .capture_compare_flag(capture_compare_flag));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each access ends one step after the taking edge, so its effect has landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    write_data <= d;
    write_en <= 1'b1;
    @(posedge clk);
    write_en <= 1'b0;
    #1;
  endtask

  task automatic rdb(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    read_en <= 1'b1;
    @(posedge clk);
    read_en <= 1'b0;
    #1;
    rd = read_data;
  endtask

  task automatic check_reset();
    for (int i = 0; i < MODULE_COUNT; i++) begin
      rdb(low_addr[i]);
      chk(rd, RESET_BYTE);
      rdb(high_addr[i]);
      chk(rd, RESET_BYTE);
    end
    rdb(ADDR_COUNTER_HIGH);
    chk(rd, RESET_BYTE);
    chk(comparator_enable, '0);
    chk(capture_compare_flag, '0);
    chk(array_counter, RESET_WORD);
  endtask

  task automatic check_counter_bytes();
    @(posedge clk);
    page <= 8'h0f;
    wr(ADDR_COUNTER_LOW, 8'h34);
    wr(ADDR_COUNTER_HIGH, 8'h12);
    chk(array_counter, 16'h1234);
    rdb(ADDR_COUNTER_LOW);
    chk(rd, 8'h34);
    wr(ADDR_COUNTER_HIGH, 8'h56);
    rdb(ADDR_COUNTER_HIGH);
    chk(rd, 8'h12);
    rdb(ADDR_COUNTER_LOW);
    rdb(ADDR_COUNTER_HIGH);
    chk(rd, 8'h56);
  endtask

  task automatic check_watchdog_lock();
    @(posedge clk);
    watchdog_enable <= 1'b1;
    wr(ADDR_COUNTER_LOW, 8'haa);
    wr(ADDR_COUNTER_HIGH, 8'hbb);
    chk(array_counter, 16'h5634);
    @(posedge clk);
    watchdog_enable <= 1'b0;
    wr(ADDR_COUNTER_LOW, 8'h10);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    chk(array_counter, 16'h0010);
  endtask

  task automatic check_module_values();
    for (int i = 0; i < MODULE_COUNT; i++) begin
      @(posedge clk);
      page <= 8'(i * 7 + 1);
      wr(high_addr[i], 8'ha0 + 8'(i));
      chk(comparator_enable[i], 1'b1);
      wr(low_addr[i], 8'h50 + 8'(i));
      chk(comparator_enable[i], 1'b0);
      wr(high_addr[i], 8'ha0 + 8'(i));
      chk(comparator_enable[i], 1'b1);
      rdb(low_addr[i]);
      chk(rd, 8'h50 + 8'(i));
      rdb(high_addr[i]);
      chk(rd, 8'ha0 + 8'(i));
    end
  endtask

  // Module 2 is armed and module 3 is left disarmed on the same value.
  task automatic check_match();
    wr(ADDR_MODULE2_VALUE_LOW, 8'h18);
    wr(ADDR_MODULE2_VALUE_HIGH, 8'h00);
    wr(ADDR_MODULE3_VALUE_HIGH, 8'h00);
    wr(ADDR_MODULE3_VALUE_LOW, 8'h18);
    @(posedge clk);
    match_enable <= 5'h1f;
    counter_run <= 1'b1;
    repeat (12) @(posedge clk);
    counter_run <= 1'b0;
    #1;
    chk(capture_compare_flag, 5'h04);
    @(posedge clk);
    flag_clear <= 5'h1f;
    @(posedge clk);
    flag_clear <= 5'h00;
    #1;
    chk(capture_compare_flag, 5'h00);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_CEILING) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    page = 8'h00;
    write_en = 1'b0;
    read_en = 1'b0;
    write_data = 8'h00;
    counter_run = 1'b0;
    watchdog_enable = 1'b0;
    match_enable = 5'h00;
    flag_clear = 5'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    check_counter_bytes();
    check_watchdog_lock();
    check_module_values();
    check_match();
    conclude();
  end
endmodule
